// >>> core/sdp_pkg.sv
package sdp_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_TOP     = 8'h04;
    localparam logic [7:0] ADDR_COMPARE = 8'h08;
    localparam logic [7:0] ADDR_COUNT   = 8'h0c;
    localparam logic [7:0] ADDR_PINCFG  = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_MASK    = 8'h18;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int          CNT_W        = 10;
    localparam logic [9:0]  CNT_MAX      = 10'h3ff;
    localparam logic [9:0]  TOP_RST      = 10'h3ff;
    localparam logic [9:0]  COMPARE_RST  = 10'h000;
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [3:0]  PINCFG_RST   = 4'h0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_MODE_SEL_BIT  = 0;
    localparam int CTRL_SLOPE_BIT     = 1;
    localparam int CTRL_OMODE_LSB     = 2;
    localparam int CTRL_TOGGLE_BIT    = 4;
    localparam int CTRL_PRESC_LSB     = 5;
    localparam int PIN_DIR_TRUE_BIT   = 0;
    localparam int PIN_DIR_INV_BIT    = 1;
    localparam int PIN_PORT_TRUE_BIT  = 2;
    localparam int PIN_PORT_INV_BIT   = 3;
    localparam int STATUS_OVF_BIT     = 0;

    // ------------------------------------------------------------
    // Output-mode field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] OMODE_OFF   = 2'h0;
    localparam logic [1:0] OMODE_COMPL = 2'h1;
    localparam logic [1:0] OMODE_NONINV = 2'h2;
    localparam logic [1:0] OMODE_INV   = 2'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] prescale;
        logic       toggle_en;
        logic [1:0] output_mode_field;
        logic       slope_select;
        logic       pwm_mode_select;
    } sdp_ctrl_s;

    typedef struct packed {
        logic port_inv;
        logic port_true;
        logic dir_inv;
        logic dir_true;
    } sdp_pincfg_s;

    typedef enum logic [1:0] {
        DIR_UP   = 2'b00,
        DIR_DOWN = 2'b01
    } sdp_dir_e;

endpackage

// >>> core/sdp_pwm.sv
module sdp_pwm (
    input  wire logic        i_sys_clk,
    input  wire logic        i_srst,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic             o_pin_true,
    output logic             o_pin_true_oe,
    output logic             o_pin_inv,
    output logic             o_pin_inv_oe,
    output logic             o_irq
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [7:0] presc_mask(input logic [2:0] sel);
        presc_mask = 8'((9'h001 << sel) - 9'h001);
    endfunction

    function automatic logic [9:0] lo10(input logic [31:0] w);
        lo10 = w[9:0];
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    sdp_pkg::sdp_ctrl_s   ctrl_q;
    sdp_pkg::sdp_pincfg_s pincfg_q;
    logic [9:0]           top_q;
    logic [9:0]           cmp_shadow_q;
    logic [9:0]           cmp_active_q;
    logic [1:0]           omode_active_q;
    logic [9:0]           count_q;
    logic [9:0]           spike_cnt_q;
    sdp_pkg::sdp_dir_e    dir_q;
    logic                 wave_q;
    logic [7:0]           presc_q;
    logic                 ovf_q;
    logic                 mask_q;

    // Bus pipeline
    logic                 dph_wr_q;
    logic [7:0]           dph_addr_q;
    logic [31:0]          hrdata_q;

    // ------------------------------------------------------------
    // AHB-Lite address phase
    // ------------------------------------------------------------
    logic       aph_valid;
    logic       aph_read;
    logic [7:0] aph_addr;
    logic [31:0] rd_word;
    logic       status_rd;

    assign aph_valid = i_hsel && i_htrans[1] && i_hready;
    assign aph_read  = aph_valid && !i_hwrite;
    assign aph_addr  = (i_haddr[31:8] == 24'h000000) ? i_haddr[7:0] : 8'hff;
    assign status_rd = aph_read && (aph_addr == sdp_pkg::ADDR_STATUS);

    always_comb begin
        rd_word = 32'h00000000;
        case (aph_addr)
            sdp_pkg::ADDR_CTRL:    rd_word = {24'h000000, ctrl_q};
            sdp_pkg::ADDR_TOP:     rd_word = {22'h0, top_q};
            sdp_pkg::ADDR_COMPARE: rd_word = {22'h0, cmp_shadow_q};
            sdp_pkg::ADDR_COUNT:   rd_word = {22'h0, count_q};
            sdp_pkg::ADDR_PINCFG:  rd_word = {28'h0, pincfg_q};
            sdp_pkg::ADDR_STATUS:  rd_word = {31'h0, ovf_q};
            sdp_pkg::ADDR_MASK:    rd_word = {31'h0, mask_q};
            default:               rd_word = 32'h00000000;
        endcase
    end

    // Read data registered at the address phase: zero wait states
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            dph_wr_q   <= 1'b0;
            dph_addr_q <= 8'h00;
            hrdata_q   <= 32'h00000000;
        end else begin
            dph_wr_q   <= aph_valid && i_hwrite;
            dph_addr_q <= aph_addr;
            if (aph_read) begin
                hrdata_q <= rd_word;
            end
        end
    end

    logic wr_ctrl;
    logic wr_top;
    logic wr_cmp;
    logic wr_pin;
    logic wr_mask;

    assign wr_ctrl = dph_wr_q && (dph_addr_q == sdp_pkg::ADDR_CTRL);
    assign wr_top  = dph_wr_q && (dph_addr_q == sdp_pkg::ADDR_TOP);
    assign wr_cmp  = dph_wr_q && (dph_addr_q == sdp_pkg::ADDR_COMPARE);
    assign wr_pin  = dph_wr_q && (dph_addr_q == sdp_pkg::ADDR_PINCFG);
    assign wr_mask = dph_wr_q && (dph_addr_q == sdp_pkg::ADDR_MASK);

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ctrl_q       <= sdp_pkg::CTRL_RST;
            top_q        <= sdp_pkg::TOP_RST;
            cmp_shadow_q <= sdp_pkg::COMPARE_RST;
            pincfg_q     <= sdp_pkg::PINCFG_RST;
            mask_q       <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= i_hwdata[7:0];
            end
            if (wr_top) begin
                top_q <= lo10(i_hwdata);
            end
            if (wr_cmp) begin
                cmp_shadow_q <= lo10(i_hwdata);
            end
            if (wr_pin) begin
                pincfg_q <= i_hwdata[3:0];
            end
            if (wr_mask) begin
                mask_q <= i_hwdata[sdp_pkg::STATUS_OVF_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    logic tick;
    logic running;

    assign running = ctrl_q.pwm_mode_select;
    assign tick    = running && ((presc_q & presc_mask(ctrl_q.prescale))
                                 == presc_mask(ctrl_q.prescale));

    always_ff @(posedge i_sys_clk) begin
        if (i_srst || !running) begin
            presc_q <= 8'h00;
        end else begin
            presc_q <= tick ? 8'h00 : presc_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic       dual;
    logic [9:0] count_d;
    sdp_pkg::sdp_dir_e dir_d;
    logic       cycle_end;
    logic       ovf_event;

    assign dual = ctrl_q.slope_select;

    always_comb begin
        count_d   = count_q;
        dir_d     = dir_q;
        cycle_end = 1'b0;
        ovf_event = 1'b0;
        if (!dual) begin
            if (count_q >= top_q) begin
                count_d   = 10'h000;
                cycle_end = 1'b1;
            end else begin
                count_d = count_q + 10'h001;
            end
            ovf_event = (count_d == top_q);
        end else begin
            if (dir_q == sdp_pkg::DIR_UP) begin
                if (count_q >= top_q) begin
                    dir_d   = sdp_pkg::DIR_DOWN;
                    count_d = (top_q == 10'h000) ? 10'h000 : count_q - 10'h001;
                end else begin
                    count_d = count_q + 10'h001;
                end
            end else begin
                if (count_q == 10'h000) begin
                    dir_d   = sdp_pkg::DIR_UP;
                    count_d = (top_q == 10'h000) ? 10'h000 : 10'h001;
                end else begin
                    count_d = count_q - 10'h001;
                end
            end
            cycle_end = (count_d == 10'h000);
            ovf_event = (count_d == 10'h000);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            count_q      <= 10'h000;
            dir_q        <= sdp_pkg::DIR_UP;
            cmp_active_q <= sdp_pkg::COMPARE_RST;
            spike_cnt_q  <= 10'h000;
        end else if (tick) begin
            count_q     <= count_d;
            dir_q       <= dir_d;
            spike_cnt_q <= spike_cnt_q + 10'h001;
            if (cycle_end) begin
                cmp_active_q <= cmp_shadow_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Waveform generator
    // ------------------------------------------------------------
    logic match;
    logic inv;
    logic wave_d;

    // Match is judged on the value the counter moves to
    assign match = (count_d == cmp_active_q);
    assign inv   = (omode_active_q == sdp_pkg::OMODE_INV);

    always_comb begin
        wave_d = wave_q;
        if (!dual) begin
            if (top_q == 10'h000) begin
                // Counter is stuck at zero; spike on a 1024-tick period
                wave_d = (spike_cnt_q == sdp_pkg::CNT_MAX) ^ inv;
            end else if (top_q == sdp_pkg::CNT_MAX) begin
                wave_d = !inv;
            end else if (ctrl_q.toggle_en &&
                         omode_active_q == sdp_pkg::OMODE_COMPL) begin
                if (match) begin
                    wave_d = !wave_q;
                end
            end else if (match) begin
                wave_d = inv;
            end else if (cycle_end) begin
                wave_d = !inv;
            end
        end else begin
            if (top_q == 10'h000) begin
                wave_d = inv;
            end else if (top_q == sdp_pkg::CNT_MAX) begin
                wave_d = !inv;
            end else if (match) begin
                wave_d = (dir_d == sdp_pkg::DIR_UP) ? inv : !inv;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            wave_q         <= 1'b0;
            omode_active_q <= sdp_pkg::OMODE_OFF;
        end else if (tick) begin
            wave_q <= wave_d;
            if (match) begin
                omode_active_q <= ctrl_q.output_mode_field;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin takeover
    // ------------------------------------------------------------
    logic take_true;
    logic take_inv;

    assign take_true = running && (omode_active_q != sdp_pkg::OMODE_OFF);
    assign take_inv  = running && (omode_active_q == sdp_pkg::OMODE_COMPL);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_pin_true    <= 1'b0;
            o_pin_inv     <= 1'b0;
            o_pin_true_oe <= 1'b0;
            o_pin_inv_oe  <= 1'b0;
        end else begin
            o_pin_true_oe <= pincfg_q.dir_true;
            o_pin_inv_oe  <= pincfg_q.dir_inv;
            o_pin_true    <= (take_true && pincfg_q.dir_true) ? wave_q
                                                               : pincfg_q.port_true;
            o_pin_inv     <= (take_inv && pincfg_q.dir_inv) ? !wave_q
                                                             : pincfg_q.port_inv;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    logic ovf_set;

    assign ovf_set = tick && ovf_event;

    // Set wins over a clearing read in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ovf_q <= 1'b0;
        end else if (ovf_set) begin
            ovf_q <= 1'b1;
        end else if (status_rd) begin
            ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= ovf_q && mask_q;
        end
    end

    assign o_hrdata    = hrdata_q;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

endmodule // sdp_pwm

// >>> tb/sdp_power_stage.sv
module sdp_power_stage (
    input  wire logic i_pin,
    input  wire logic i_oe,
    output logic      o_pad
);
    timeunit 1ns;
    timeprecision 1ps;
    // Gate driver input has a pull-down, so a released pin reads low
    assign o_pad = i_oe ? i_pin : 1'b0;
endmodule // sdp_power_stage

// >>> tb/sdp_pwm_asserts.sv
module sdp_pwm_asserts (
    input wire logic        i_sys_clk,
    input wire logic        i_srst,
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic [2:0]  i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic        i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    input wire logic        o_pin_true,
    input wire logic        o_pin_true_oe,
    input wire logic        o_pin_inv,
    input wire logic        o_pin_inv_oe,
    input wire logic        o_irq
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    // ------------------------------
    // Shadow of written config
    // ------------------------------
    logic       take, rd_take, wr_q, mode_q, cpl_q, mask_q;
    logic [7:0] addr_q;
    logic [3:0] pin_q;
    logic [2:0] stab_q;
    assign take    = i_hsel && i_htrans[1] && i_hready;
    assign rd_take = take && !i_hwrite;
    always_ff @(posedge i_sys_clk) begin
        wr_q   <= !i_srst && take && i_hwrite && i_haddr[31:8] == 24'h0;
        addr_q <= i_haddr[7:0];
    end
    // Pins lag config, so only settled config is judged
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || wr_q) stab_q <= 3'h0;
        else if (stab_q != 3'h7) stab_q <= stab_q + 3'h1;
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            mode_q <= 1'b0;
            cpl_q  <= 1'b0;
            mask_q <= 1'b0;
            pin_q  <= 4'h0;
        end else if (wr_q) begin
            if (addr_q == sdp_pkg::ADDR_CTRL) mode_q <= i_hwdata[0];
            if (addr_q == sdp_pkg::ADDR_CTRL && i_hwdata[3:2] == 2'h1) cpl_q <= 1'b1;
            if (addr_q == sdp_pkg::ADDR_MASK) mask_q <= i_hwdata[0];
            if (addr_q == sdp_pkg::ADDR_PINCFG) pin_q <= i_hwdata[3:0];
        end
    end
    // ------------------------------
    // Properties
    // ------------------------------
    ready_const_a: assert property (o_hreadyout == 1'b1)
        else $error("hreadyout low");
    resp_okay_a: assert property (o_hresp == 1'b0)
        else $error("hresp not okay");
    reset_quiet_a: assert property ($fell(i_srst) |-> o_hrdata == 32'h0 &&
        !(o_pin_true || o_pin_inv || o_pin_true_oe || o_pin_inv_oe || o_irq))
        else $error("outputs active after reset");
    rd_stand_a: assert property (!rd_take |=> $stable(o_hrdata))
        else $error("read data moved");
    unmapped_read_a: assert property (rd_take &&
        (i_haddr[31:8] != 24'h0 || i_haddr[7:0] > 8'h18) |=> o_hrdata == 32'h0)
        else $error("unmapped read not zero");
    oe_follow_a: assert property (stab_q > 3'h2 |->
        o_pin_true_oe == pin_q[0] && o_pin_inv_oe == pin_q[1])
        else $error("enable differs from direction");
    frozen_port_a: assert property (stab_q > 3'h2 && !mode_q |->
        o_pin_true == pin_q[2] && o_pin_inv == pin_q[3])
        else $error("stopped timer drives pins");
    inv_port_a: assert property (stab_q > 3'h2 && !cpl_q |-> o_pin_inv == pin_q[3])
        else $error("inverted pin taken without mode 1");
    irq_masked_a: assert property (stab_q > 3'h2 && !mask_q |-> !o_irq)
        else $error("masked interrupt raised");
    cover property (rd_take && i_haddr[7:0] == sdp_pkg::ADDR_STATUS);
    cover property ($rose(o_irq));
    cover property (o_pin_true_oe && o_pin_inv_oe && $rose(o_pin_inv));
endmodule // sdp_pwm_asserts

// >>> tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic        hready, hresp, p_t, oe_t, p_i, oe_i, irq, pad_t, pad_i;
    int          errors = 0, num_checks = 0;
    always #2.5 clk = ~clk;
    sdp_pwm i_sdp_pwm (
        .i_sys_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .o_pin_true(p_t),
        .o_pin_true_oe(oe_t), .o_pin_inv(p_i), .o_pin_inv_oe(oe_i), .o_irq(irq));
    sdp_power_stage i_sdp_power_stage_t (.i_pin(p_t), .i_oe(oe_t), .o_pad(pad_t));
    sdp_power_stage i_sdp_power_stage_i (.i_pin(p_i), .i_oe(oe_i), .o_pad(pad_i));
    // ------------------------------
    // Bus and compare helpers
    // ------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Entered and left just after a rising edge; select stays up
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        check(r, exp);
    endtask
    // Counts high cycles on both pads; a window of whole periods is phase free
    task automatic run_case(input logic [9:0] top, input logic [9:0] cmp,
                            input logic [7:0] ctrl, input int w, input int et, input int ei);
        int ht;
        int hi;
        ht = 0;
        hi = 0;
        wr(sdp_pkg::ADDR_TOP, {22'h0, top});
        wr(sdp_pkg::ADDR_COMPARE, {22'h0, cmp});
        wr(sdp_pkg::ADDR_CTRL, {24'h0, ctrl});
        repeat (64) @(posedge clk);
        repeat (w) begin
            @(posedge clk);
            if (pad_t === 1'b1) ht++;
            if (pad_i === 1'b1) hi++;
        end
        check(ht, et);
        check(hi, ei);
    endtask
    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic test_reset_values;
        rd_chk(sdp_pkg::ADDR_CTRL, {24'h0, sdp_pkg::CTRL_RST});
        rd_chk(sdp_pkg::ADDR_TOP, {22'h0, sdp_pkg::TOP_RST});
        rd_chk(sdp_pkg::ADDR_COMPARE, {22'h0, sdp_pkg::COMPARE_RST});
        rd_chk(sdp_pkg::ADDR_PINCFG, {28'h0, sdp_pkg::PINCFG_RST});
        rd_chk(sdp_pkg::ADDR_STATUS, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rd_chk(8'h40, 32'h0);
    endtask
    task automatic test_port_pins;
        wr(sdp_pkg::ADDR_PINCFG, 32'hf);
        repeat (4) @(posedge clk);
        check({pad_t, pad_i}, 2'h3);
        wr(sdp_pkg::ADDR_PINCFG, 32'hc);
        repeat (4) @(posedge clk);
        check({oe_t, oe_i, pad_t, pad_i}, 4'h0);
        rd_chk(sdp_pkg::ADDR_COUNT, 32'h0);
        wr(sdp_pkg::ADDR_PINCFG, 32'h3);
    endtask
    task automatic test_single_slope;
        run_case(10'h7, 10'h3, 8'h01, 32, 0, 0);
        run_case(10'h7, 10'h3, 8'h09, 32, 12, 0);
        run_case(10'h7, 10'h3, 8'h0d, 32, 20, 0);
        run_case(10'h7, 10'h3, 8'h05, 32, 12, 20);
        run_case(10'h7, 10'h3, 8'h29, 64, 24, 0);
        run_case(10'h3ff, 10'h3, 8'h09, 64, 64, 0);
        run_case(10'h0, 10'h0, 8'h09, 1024, 1, 0);
    endtask
    task automatic test_dual_slope;
        run_case(10'h7, 10'h3, 8'h0b, 56, 24, 0);
        run_case(10'h3ff, 10'h3, 8'h0b, 64, 64, 0);
        run_case(10'h0, 10'h0, 8'h0b, 64, 0, 0);
        run_case(10'h7, 10'h3, 8'h0f, 56, 32, 0);
        run_case(10'h7, 10'h3, 8'h07, 56, 24, 32);
    endtask
    task automatic test_toggle;
        run_case(10'h3, 10'h1, 8'h15, 32, 16, 16);
    endtask
    // Slow ticks so a compare write lands well inside one period
    task automatic test_compare_update;
        logic [31:0] r;
        int          n;
        wr(sdp_pkg::ADDR_TOP, 32'h7);
        wr(sdp_pkg::ADDR_COMPARE, 32'h3);
        wr(sdp_pkg::ADDR_MASK, 32'h1);
        wr(sdp_pkg::ADDR_CTRL, 32'he9);
        repeat (1100) @(posedge clk);
        bus(sdp_pkg::ADDR_STATUS, 1'b0, 32'h0, r);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq !== 1'b1 && n < 1100);
        check(n < 1100, 1'b1);
        repeat (198) @(posedge clk);
        wr(sdp_pkg::ADDR_COMPARE, 32'h6);
        repeat (372) @(posedge clk);
        check(pad_t, 1'b0);
        repeat (1024) @(posedge clk);
        check(pad_t, 1'b1);
        wr(sdp_pkg::ADDR_CTRL, 32'h0);
    endtask
    task automatic test_overflow;
        logic [31:0] r;
        for (int k = 0; k < 2; k++) begin
            wr(sdp_pkg::ADDR_MASK, 32'h1);
            wr(sdp_pkg::ADDR_TOP, 32'h7);
            wr(sdp_pkg::ADDR_CTRL, k == 0 ? 32'h09 : 32'h0b);
            repeat (40) @(posedge clk);
            check(irq, 1'b1);
            rd_chk(sdp_pkg::ADDR_STATUS, 32'h1);
            wr(sdp_pkg::ADDR_CTRL, 32'h0);
            bus(sdp_pkg::ADDR_STATUS, 1'b0, 32'h0, r);
            rd_chk(sdp_pkg::ADDR_STATUS, 32'h0);
            repeat (3) @(posedge clk);
            check(irq, 1'b0);
        end
        wr(sdp_pkg::ADDR_MASK, 32'h0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        test_reset_values();
        test_port_pins();
        test_single_slope();
        test_dual_slope();
        test_toggle();
        test_compare_update();
        test_overflow();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        summarize();
    end
endmodule // testbench

bind sdp_pwm sdp_pwm_asserts i_sdp_pwm_asserts (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .o_pin_true(o_pin_true), .o_pin_true_oe(o_pin_true_oe),
    .o_pin_inv(o_pin_inv), .o_pin_inv_oe(o_pin_inv_oe), .o_irq(o_irq));
